// >>> verilog/cpdc_cfg.svh
// Constants for the clock power-down control block.
`ifndef CPDC_CFG_SVH
`define CPDC_CFG_SVH

// Clock rate of the internal processor clock in MHz.
`define CPDC_CLK_MHZ 50
// Power-up latency limit in milliseconds.
`define CPDC_WAKE_MS 3
// Power-up latency limit in clock cycles, rounded down.
`define CPDC_WAKE_CYC (`CPDC_WAKE_MS * 1000 * `CPDC_CLK_MHZ)
// Margin kept under the limit for synchroniser and restart cycles.
`define CPDC_WAKE_MARGIN 8
// Width of the oscillator settle counter.
`define CPDC_WAIT_W 18
// Reset value of the synchroniser flops: all inputs inactive high.
`define CPDC_SYNC_RST 3'h7
// Bit positions of the synchronised inputs.
`define CPDC_SYNC_PD 0
`define CPDC_SYNC_BUS 1
`define CPDC_SYNC_CPU 2
// Phase divider value at which the next phase is the common low point.
`define CPDC_CNT_LAST 2'h3

`endif

// >>> verilog/cpdc_pkg.sv
// Types for the clock power-down control block.
package cpdc_pkg;

    // Power sequencing states, one-hot.
    typedef enum logic [4:0] {
        CPDC_RUN  = 5'h01,
        CPDC_PARK = 5'h02,
        CPDC_STOP = 5'h04,
        CPDC_DOWN = 5'h08,
        CPDC_WAKE = 5'h10
    } cpdc_pwr_e;

    // Output clocks and analog enables, all registered.
    typedef struct packed {
        logic proc_clk;
        logic bus_clk;
        logic free_bus_clk;
        logic ref_clk;
        logic osc_en;
        logic vco_en;
    } cpdc_out_s;

    // Whole state of the control block.
    typedef struct packed {
        cpdc_pwr_e  st;
        logic [1:0] cnt;
        logic       en_all;
        logic       en_proc;
        logic       en_bus;
        logic [17:0] wait_cnt;
        cpdc_out_s  o;
    } cpdc_state_s;

endpackage

// >>> verilog/cpdc_sync.sv
// Two-flop synchroniser for the asynchronous control inputs.
`timescale 1ns/100ps
`include "cpdc_cfg.svh"

module cpdc_sync (
    input  wire logic       clock, // System clock.
    input  wire logic       rst_n, // Synchronous reset, active low.
    input  wire logic [2:0] din,   // Asynchronous inputs.
    output logic      [2:0] dout   // Synchronised inputs.
);

    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] sync;
    } cpdc_sync_s;

    cpdc_sync_s s;
    cpdc_sync_s next_s;

    // The first stage feeds only the second stage.
    always_comb begin
        next_s.meta = din;
        next_s.sync = s.meta;
    end

    // Register both stages; reset takes the inactive level.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s <= {`CPDC_SYNC_RST, `CPDC_SYNC_RST};
        end else begin
            s <= next_s;
        end
    end

    assign dout = s.sync;

endmodule // cpdc_sync

// >>> verilog/cpdc_ctrl.sv
// Power-down and clock-stop control for the clock synthesizer.
// What this block does
// - Bus halt input synchronised before gating.
// - Other clocks keep running during bus halt.
// - Power-down input synchronised before acting.
// - No internal clock runs when powered down.
// - Outputs parked low before oscillators stop.
// - First valid clocks within 3 ms.
// - Power-down completes within eight processor cycles.
// - Halt inputs ignored during power transitions.
// - Bus clocks stop low, restart full pulse.
// - Bus halt leaves free bus clock alone.
// - Processor halt stops processor clocks low.
`timescale 1ns/100ps
`include "cpdc_cfg.svh"

module cpdc_ctrl
    import cpdc_pkg::*;
#(
    parameter int WAKE_WAIT = `CPDC_WAKE_CYC - `CPDC_WAKE_MARGIN // Oscillator settle cycles.
) (
    input  wire logic clock,              // Internal processor clock, 50 MHz.
    input  wire logic rst_n,              // Synchronous reset, active low.
    input  wire logic power_down_n,       // Asynchronous power-down request, active low.
    input  wire logic bus_halt_n,         // Asynchronous bus clock halt, active low.
    input  wire logic proc_halt_n,        // Asynchronous processor clock halt, active low.
    output logic      processor_clock_out, // Gated processor clock.
    output logic      bus_clock_out,      // Gated bus clock.
    output logic      free_bus_clock_out, // Free-running bus clock.
    output logic      ref_clock_out,      // Reference clock.
    output logic      osc_enable,         // Crystal oscillator enable.
    output logic      vco_enable,         // VCO enable.
    output logic      powered_down        // High while in power-down.
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisation.

    logic [2:0] sync_in;
    logic       pd_s;
    logic       bus_s;
    logic       cpu_s;

    // All three control inputs pass two flops before use.
    cpdc_sync u_sync (
        .clock (clock),
        .rst_n (rst_n),
        .din   ({proc_halt_n, bus_halt_n, power_down_n}),
        .dout  (sync_in)
    );

    assign pd_s  = sync_in[`CPDC_SYNC_PD];
    assign bus_s = sync_in[`CPDC_SYNC_BUS];
    assign cpu_s = sync_in[`CPDC_SYNC_CPU];

    ////////////////////////////////////////////////////////////////////////////
    // State and next-state logic.

    cpdc_state_s s;
    cpdc_state_s next_s;
    logic        at_low;

    // True in the cycle after which every divided clock starts a low phase.
    function automatic logic low_point(input logic [1:0] cnt);
        return cnt == `CPDC_CNT_LAST;
    endfunction

    // Sequence power states; enables change only at the common low point.
    always_comb begin
        next_s = s;
        at_low = low_point(s.cnt);
        case (s.st)
            CPDC_RUN: begin
                next_s.cnt = s.cnt + 2'h1;
                if (!pd_s) begin
                    next_s.st = CPDC_PARK;
                end else if (at_low) begin
                    next_s.en_proc = cpu_s;
                    next_s.en_bus  = bus_s;
                end
            end
            CPDC_PARK: begin
                next_s.cnt = s.cnt + 2'h1;
                if (at_low) begin
                    next_s.en_all  = 1'b0;
                    next_s.en_proc = 1'b0;
                    next_s.en_bus  = 1'b0;
                    next_s.st      = CPDC_STOP;
                end
            end
            CPDC_STOP: begin
                next_s.cnt      = 2'h0;
                next_s.o.osc_en = 1'b0;
                next_s.o.vco_en = 1'b0;
                next_s.st       = CPDC_DOWN;
            end
            CPDC_DOWN: begin
                next_s.cnt = 2'h0;
                if (pd_s) begin
                    next_s.o.osc_en = 1'b1;
                    next_s.o.vco_en = 1'b1;
                    next_s.wait_cnt = WAKE_WAIT[17:0];
                    next_s.st       = CPDC_WAKE;
                end
            end
            CPDC_WAKE: begin
                next_s.cnt = 2'h0;
                if (s.wait_cnt == 18'h0) begin
                    next_s.en_all  = 1'b1;
                    next_s.en_proc = cpu_s;
                    next_s.en_bus  = bus_s;
                    next_s.st      = CPDC_RUN;
                end else begin
                    next_s.wait_cnt = s.wait_cnt - 18'h1;
                end
            end
            default: begin
                next_s.st = CPDC_RUN;
            end
        endcase
        // Outputs follow the next phase so every pulse is whole.
        next_s.o.proc_clk     = next_s.cnt[0] & next_s.en_proc & next_s.en_all;
        next_s.o.bus_clk      = next_s.cnt[1] & next_s.en_bus & next_s.en_all;
        next_s.o.free_bus_clk = next_s.cnt[1] & next_s.en_all;
        next_s.o.ref_clk      = next_s.cnt[1] & next_s.en_all;
    end

    // Register the state; reset leaves the clocks running.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s <= '{st: CPDC_RUN, cnt: 2'h0, en_all: 1'b1, en_proc: 1'b1, en_bus: 1'b1,
                   wait_cnt: 18'h0, o: '{osc_en: 1'b1, vco_en: 1'b1, default: 1'b0}};
        end else begin
            s <= next_s;
        end
    end

    assign processor_clock_out = s.o.proc_clk;
    assign bus_clock_out       = s.o.bus_clk;
    assign free_bus_clock_out  = s.o.free_bus_clk;
    assign ref_clock_out       = s.o.ref_clk;
    assign osc_enable          = s.o.osc_en;
    assign vco_enable          = s.o.vco_en;
    assign powered_down        = (s.st == CPDC_DOWN);

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the sequencing.

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_park_before_off: assert property ($fell(osc_enable) |->
        $past(!processor_clock_out && !bus_clock_out && !free_bus_clock_out && !ref_clock_out))
        else $error("Oscillator stopped before outputs were parked.");

    a_down_is_quiet: assert property (powered_down |->
        !osc_enable && !vco_enable && !processor_clock_out && !free_bus_clock_out && !ref_clock_out)
        else $error("A clock runs while powered down.");

    a_pd_latency: assert property ((s.st == CPDC_RUN && !pd_s) |->
        ##[1:5] (s.st == CPDC_STOP && !processor_clock_out && !free_bus_clock_out && !ref_clock_out) ##1 !osc_enable)
        else $error("Power-down took too long.");

    a_pd_synced: assert property ((s.st == CPDC_RUN && $fell(power_down_n)) |=> s.st == CPDC_RUN)
        else $error("Power-down acted on an unsynchronised input.");

    a_wake_bound: assert property (s.st == CPDC_WAKE |-> s.wait_cnt < 18'(`CPDC_WAKE_CYC))
        else $error("Wake wait exceeds the power-up limit.");

    a_wake_order: assert property ($rose(free_bus_clock_out) |-> osc_enable && vco_enable)
        else $error("Outputs ungated before oscillators ran.");

    a_bus_low_stop: assert property ($fell(s.en_bus) |-> !bus_clock_out)
        else $error("Bus clock stopped in the high state.");

    a_bus_full_high: assert property ($rose(bus_clock_out) |=> bus_clock_out)
        else $error("Truncated bus clock high pulse.");

    a_bus_from_sync: assert property ((s.st == CPDC_RUN && $changed(s.en_bus)) |->
        s.en_bus == $past(bus_s))
        else $error("Bus gate did not follow the synchronised halt.");

    a_free_unaffected: assert property ((s.st == CPDC_RUN && $past(s.st == CPDC_RUN) &&
        $past(s.st == CPDC_RUN, 2) && $past(rst_n, 2)) |->
        free_bus_clock_out != $past(free_bus_clock_out, 2) && ref_clock_out == free_bus_clock_out)
        else $error("Free bus or reference clock disturbed.");

    a_proc_halt: assert property ((s.st == CPDC_RUN && pd_s && !cpu_s && at_low) |=>
        !processor_clock_out ##1 !processor_clock_out)
        else $error("Processor clock not held low on halt.");

    a_halt_ignored: assert property ((s.st == CPDC_STOP || s.st == CPDC_DOWN) |=>
        !s.en_bus && !s.en_proc)
        else $error("Halt inputs acted during power-down.");

    // Gate edges and idle states: a gate only moves while its clock is low.

    a_proc_low_stop: assert property ($fell(s.en_proc) |-> !processor_clock_out)
        else $error("Processor clock stopped in the high state.");

    a_proc_clean_start: assert property ($rose(s.en_proc) |-> !processor_clock_out)
        else $error("Processor clock restarted mid pulse.");

    a_bus_halt_held: assert property ((s.st == CPDC_RUN && pd_s && !bus_s && at_low) |=>
        !bus_clock_out ##1 !bus_clock_out)
        else $error("Bus clock not held low on halt.");

    a_stop_parked: assert property (s.st == CPDC_STOP |->
        !processor_clock_out && !bus_clock_out && !free_bus_clock_out && !ref_clock_out)
        else $error("Outputs not parked when oscillators stop.");

    a_park_osc_on: assert property (s.st == CPDC_PARK |-> osc_enable && vco_enable)
        else $error("Oscillators stopped while outputs still ran.");

    a_wake_quiet: assert property (s.st == CPDC_WAKE |->
        osc_enable && vco_enable && !processor_clock_out && !bus_clock_out && !free_bus_clock_out && !ref_clock_out)
        else $error("Outputs ungated during oscillator settling.");

    a_down_held: assert property ((powered_down && !pd_s) |=> powered_down)
        else $error("Power-down state left while still requested.");

    a_down_no_count: assert property (powered_down |-> s.cnt == 2'h0)
        else $error("Phase divider runs while powered down.");

endmodule // cpdc_ctrl

// >>> test/cpdc_pm.sv
// Model of the power-management logic that drives the control pins.
`timescale 1ns/100ps

module cpdc_pm (
    input  wire logic clock,        // System clock.
    input  wire logic pd_req,       // Request for power-down.
    input  wire logic bus_req,      // Request for a bus clock halt.
    input  wire logic proc_req,     // Request for a processor clock halt.
    output logic      power_down_n, // Power-down pin, active low.
    output logic      bus_halt_n,   // Bus halt pin, active low.
    output logic      proc_halt_n   // Processor halt pin, active low.
);
    int run_cnt = 0;

    // Start with every pin inactive.
    initial begin
        power_down_n = 1'b1;
        bus_halt_n   = 1'b1;
        proc_halt_n  = 1'b1;
    end

    // Pins move at the falling edge; a bus halt waits until the release has stood 10 bus clocks.
    always @(negedge clock) begin
        power_down_n <= ~pd_req;
        proc_halt_n  <= ~proc_req;
        run_cnt      <= bus_halt_n ? run_cnt + 1 : 0;
        if (!bus_req) bus_halt_n <= 1'b1;
        else if (run_cnt >= 40) bus_halt_n <= 1'b0;
    end
endmodule // cpdc_pm

// >>> test/cpdc_ctrl_tb.sv
// Self-checking testbench for the clock power-down control block.
`timescale 1ns/100ps

module cpdc_ctrl_tb;
    typedef struct {int kind; int lim; longint t0;} cpdc_note_s;
    localparam int WW = 20;
    logic clock = 1'b0, rst_n = 1'b0, pd_req = 1'b0, bus_req = 1'b0, proc_req = 1'b0;
    logic power_down_n, bus_halt_n, proc_halt_n;
    logic proc_o, bus_o, free_o, ref_o, osc_o, vco_o, down_o, was_down = 1'b0, waking = 1'b0, restart = 1'b0;
    int err_count = 0, n_tests = 0, seed = 32'hda36, lo_bus = 0, hi_bus = 0, np, nb, nf;
    cpdc_note_s notes[$];
    cpdc_note_s nt;

    cpdc_pm i_cpdc_pm (.clock(clock), .pd_req(pd_req), .bus_req(bus_req), .proc_req(proc_req),
        .power_down_n(power_down_n), .bus_halt_n(bus_halt_n), .proc_halt_n(proc_halt_n));
    cpdc_ctrl #(.WAKE_WAIT(WW)) i_cpdc_ctrl (.clock(clock), .rst_n(rst_n), .power_down_n(power_down_n),
        .bus_halt_n(bus_halt_n), .proc_halt_n(proc_halt_n), .processor_clock_out(proc_o),
        .bus_clock_out(bus_o), .free_bus_clock_out(free_o), .ref_clock_out(ref_o),
        .osc_enable(osc_o), .vco_enable(vco_o), .powered_down(down_o));

    // Clock at 50 MHz.
    always #10 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////////
    // Compare one value and count it.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Print the counts and the verdict, then stop.
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Count high cycles of the processor, bus and free bus clocks over 8 cycles.
    task automatic highs(output int p, output int b, output int f);
        p = 0;
        b = 0;
        f = 0;
        repeat (8) begin
            @(negedge clock);
            p += int'(proc_o === 1'b1);
            b += int'(bus_o === 1'b1);
            f += int'(free_o === 1'b1);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Each power or restart event takes the oldest note and checks levels and timing.
    always @(posedge clock) begin
        #1;
        if (down_o === 1'b1 && !was_down) begin
            nt = notes.pop_front();
            check(nt.kind, 1);
            check({proc_o, bus_o, free_o, ref_o, osc_o, vco_o}, 0);
            check(32'(($time - nt.t0) / 20 <= nt.lim), 1);
        end
        if (was_down && down_o === 1'b0) waking = 1'b1;
        was_down = (down_o === 1'b1);
        if (waking && proc_o === 1'b1) begin
            nt = notes.pop_front();
            waking = 1'b0;
            check(nt.kind, 2);
            check({osc_o, vco_o}, 2'h3);
            check(32'(($time - nt.t0) / 20 <= nt.lim), 1);
        end
        if (bus_o === 1'b1) begin
            if (lo_bus >= 8) restart = 1'b1;
            lo_bus = 0;
            hi_bus++;
        end else begin
            if (restart && hi_bus > 0) begin
                nt = notes.pop_front();
                restart = 1'b0;
                check(nt.kind, 3);
                check(hi_bus, 2);
            end
            hi_bus = 0;
            lo_bus = rst_n ? lo_bus + 1 : 0;
        end
    end

    // Watchdog against a hang.
    initial begin
        #200000;
        err_count++;
        tally_and_finish();
    end

    // Halt and power sequences with random spacing and random halt levels.
    initial begin
        repeat (5) @(negedge clock);
        rst_n <= 1'b1;
        repeat (4) begin
            repeat (30 + ($random(seed) & 15)) @(negedge clock);
            bus_req <= 1'b1;
            repeat (60) @(negedge clock);
            highs(np, nb, nf);
            check(nb, 0);
            check(nf, 4);
            check(np, 4);
            proc_req <= 1'b1;
            repeat (10) @(negedge clock);
            highs(np, nb, nf);
            check(np, 0);
            check(nf, 4);
            notes.push_back('{3, 0, 0});
            bus_req <= 1'b0;
            proc_req <= 1'b0;
            repeat (30) @(negedge clock);
            notes.push_back('{1, 10, $time});
            pd_req <= 1'b1;
            bus_req <= 1'($random(seed));
            proc_req <= 1'($random(seed));
            repeat (15) @(negedge clock);
            check(down_o, 1);
            bus_req <= 1'b0;
            proc_req <= 1'b0;
            repeat (3) @(negedge clock);
            notes.push_back('{2, WW + 7, $time});
            notes.push_back('{3, 0, 0});
            pd_req <= 1'b0;
            repeat (WW + 20) @(negedge clock);
        end
        check(notes.size(), 0);
        tally_and_finish();
    end
endmodule // cpdc_ctrl_tb
